// ===== pfd_pkg.sv
// shared constants and types for the fault, dither and capture timer block
package pfd_pkg;

  // ---------------------------------------------------------------
  // sequence states of one timer cycle
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PFD_DEAD_A = 2'b00,
    PFD_ON_A   = 2'b01,
    PFD_DEAD_B = 2'b10,
    PFD_ON_B   = 2'b11
  } pfd_state_t;

  // ---------------------------------------------------------------
  // waveform generation modes and dither placements
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PFD_ONE_RAMP  = 2'b00,
    PFD_TWO_RAMP  = 2'b01,
    PFD_FOUR_RAMP = 2'b10,
    PFD_DUAL      = 2'b11
  } pfd_ramp_t;

  typedef enum logic [1:0] {
    PFD_PL_ON_B    = 2'b00,
    PFD_PL_ON_AB   = 2'b01,
    PFD_PL_DEAD_B  = 2'b10,
    PFD_PL_DEAD_AB = 2'b11
  } pfd_place_t;

  // ---------------------------------------------------------------
  // fault input mode codes
  // ---------------------------------------------------------------
  localparam logic [3:0] PFD_FM_OFF       = 4'h0;
  localparam logic [3:0] PFD_FM_JUMP_WAIT = 4'h1;
  localparam logic [3:0] PFD_FM_EXEC_WAIT = 4'h2;
  localparam logic [3:0] PFD_FM_EXEC_RUN  = 4'h3;
  localparam logic [3:0] PFD_FM_ALL_OFF   = 4'h4;
  localparam logic [3:0] PFD_FM_DEAD_ONLY = 4'h5;
  localparam logic [3:0] PFD_FM_ALL_WAIT  = 4'h6;
  localparam logic [3:0] PFD_FM_SW_WAIT   = 4'h7;
  localparam logic [3:0] PFD_FM_EDGE_JUMP = 4'h8;
  localparam logic [3:0] PFD_FM_EDGE_BLK  = 4'h9;
  localparam logic [3:0] PFD_FM_LEVEL_BLK = 4'ha;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] PFD_CNT_RST  = 12'h000;
  localparam logic [7:0]  PFD_BYTE_RST = 8'h00;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] dead_a;
    logic [11:0] on_a;
    logic [11:0] dead_b;
    logic [11:0] on_b;
  } pfd_lens_t;

  typedef struct packed {
    logic strobe;
    logic unit;
    logic high;
  } pfd_rd_t;

endpackage

// ===== pfd_top.sv
// fault input modes, dither and counter capture of a dead-time pwm timer
`timescale 1ns/10ps
`default_nettype none

// How it works
// (R1) mode 1: fault ends own on-time, jumps to other dead-time, waits.
// (R2) mode 2: fault ends on-time, runs other cycle, waits before own.
// (R3) mode 3: fault ends on-time, repeats other cycle while active.
// (R4) mode 4: either input forces both outputs off, counter untouched.
// (R5) mode 5: either input gives alternating dead-times only while active.
// (R6) mode 6: either input ends on-time, holds counter, then other dead-time.
// (R7) mode 7: stop until restart; restart begins dead-time A, refaults.
// (R8) mode 8: rising edge in own on-time jumps to other dead-time.
// (R9) mode 9: rising edge in own on-time blanks rest of on-time.
// (R10) mode 10: output off while active and to end of that on-time.
// (R11) accumulator adds fractional step once per timer cycle.
// (R12) overflow lengthens selected part of the next cycle by one clock.
// (R13) placement picks on B, on A and B, dead B, dead A and B.
// (R14) dual slope mode: dither adds nothing.
// (R15) one ramp: on placements add one clock, dead placements add none.
// (R16) two ramp adds 1,2,0,0; four ramp adds 1,2,1,2.
// (R17) placements adding nothing shorten the following state instead.
// (R18) two capture units copy the counter for software.
// (R19) a capture starts from its input event or software strobe.
// (R20) software reads the low byte first, then the high byte.
// (R21) event capture only while that input's action bit is set.
// (R22) completed capture sets its trigger flag.
// (R23) trigger interrupt only when its enable bit is set.
// (R24) low byte read latches the high byte for the next read.
module pfd_top
  import pfd_pkg::*;
#(
  parameter int CNT_W = 12,
  parameter int ACC_W = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             timer_enable,
  input  wire pfd_ramp_t        wave_gen_mode,
  input  wire pfd_lens_t        phase_lens,
  input  wire logic [3:0]       fault_input_mode_first,
  input  wire logic [3:0]       fault_input_mode_second,
  input  wire logic             event_in_first,
  input  wire logic             event_in_second,
  input  wire logic             restart_cmd,
  input  wire pfd_place_t       dither_place_select,
  input  wire logic [ACC_W-1:0] dither_control,
  input  wire logic [1:0]       event_action,
  input  wire logic [1:0]       sw_capture,
  input  wire logic [1:0]       irq_enable_register,
  input  wire logic [1:0]       trigger_flag_clear,
  input  wire pfd_rd_t          capture_rd,
  output logic                  wave_out_first,
  output logic                  wave_out_second,
  output logic                  trigger_flag_first,
  output logic                  trigger_flag_second,
  output logic                  trig_irq,
  output logic [7:0]            capture_rd_data,
  output logic                  counter_stopped
);

  // ---------------------------------------------------------------
  // dither placement masks, indexed by sequence state
  // ---------------------------------------------------------------
  // returns {shorten[3:0], extend[3:0]}
  function automatic logic [7:0] dither_masks(input pfd_ramp_t rm,
                                              input pfd_place_t pl);
    logic [3:0] ext;
    logic [3:0] shr;
    logic       cut;
    ext = 4'h0;
    shr = 4'h0;
    cut = (rm == PFD_ONE_RAMP) || (rm == PFD_TWO_RAMP);
    case (pl)
      PFD_PL_ON_B:    ext = 4'h8;
      PFD_PL_ON_AB:   ext = 4'ha;
      PFD_PL_DEAD_B:  ext = 4'h4;
      PFD_PL_DEAD_AB: ext = 4'h5;
      default:        ext = 4'h0;
    endcase
    if (rm == PFD_ONE_RAMP && pl == PFD_PL_ON_AB)
      shr = 4'h4;                                         // R15 R17
    if (cut && pl == PFD_PL_DEAD_B)
      shr = 4'h8;                                         // R15 R16 R17
    if (cut && pl == PFD_PL_DEAD_AB)
      shr = 4'ha;                                         // R16 R17
    if (rm == PFD_DUAL) begin
      ext = 4'h0;                                         // R14
      shr = 4'h0;
    end
    return {shr, ext};
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [1:0] ev_meta_q;
  logic [1:0] ev_sync_q;
  logic [1:0] ev_prev_q;
  wire  [1:0] act  = ev_sync_q;
  wire  [1:0] rise = ev_sync_q & ~ev_prev_q;

  // two flops before any logic sees the event inputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ev_meta_q <= 2'b00;
      ev_sync_q <= 2'b00;
      ev_prev_q <= 2'b00;
    end else begin
      ev_meta_q <= {event_in_second, event_in_first};
      ev_sync_q <= ev_meta_q;
      ev_prev_q <= ev_sync_q;
    end
  end

  // ---------------------------------------------------------------
  // sequence state and phase length
  // ---------------------------------------------------------------
  pfd_state_t       st_q;
  pfd_state_t       st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [1:0]       wait_q;
  logic [1:0]       wait_d;
  logic             stop_q;
  logic             stop_d;
  logic [ACC_W-1:0] acc_q;
  logic             ovf_q;
  logic [1:0]       blk_q;
  logic [1:0]       blk_d;
  wire  [3:0]       fmode [2];

  assign fmode[0] = fault_input_mode_first;
  assign fmode[1] = fault_input_mode_second;

  // base length of the current phase
  wire [11:0] base_len = (st_q == PFD_DEAD_A) ? phase_lens.dead_a :
                         (st_q == PFD_ON_A)   ? phase_lens.on_a   :
                         (st_q == PFD_DEAD_B) ? phase_lens.dead_b :
                                                phase_lens.on_b;

  // dither stretches or shortens the current phase by one clock
  wire [7:0]  masks    = dither_masks(wave_gen_mode, dither_place_select);
  wire        ext_now  = ovf_q & masks[st_q];                 // R12 R13
  wire        shr_now  = ovf_q & masks[4 + st_q];             // R17
  wire [12:0] len_eff  = {1'b0, base_len} + {12'h000, ext_now}
                         - {12'h000, shr_now};
  wire        at_end   = (len_eff <= 13'h001) ||
                         ({1'b0, cnt_q} >= len_eff - 13'h001);
  wire        frozen   = (|(wait_q & act)) | stop_q;
  wire        cyc_end  = timer_enable & ~frozen &
                         (st_q == PFD_ON_B) & at_end;
  wire [ACC_W:0] acc_sum = {1'b0, acc_q} + {1'b0, dither_control};

  // next sequence state with fault overrides
  always_comb begin
    logic       x;
    x      = 1'b0;
    st_d   = st_q;
    cnt_d  = cnt_q;
    wait_d = wait_q;
    stop_d = stop_q;
    if (!frozen) begin
      cnt_d = cnt_q + 1'b1;
      if (at_end) begin
        cnt_d = PFD_CNT_RST;
        st_d  = pfd_state_t'(st_q + 2'b01);
      end
    end
    if (restart_cmd && stop_q) begin
      st_d   = PFD_DEAD_A;                                // R7
      cnt_d  = PFD_CNT_RST;
      stop_d = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      x   = 1'(i);
      case (fmode[i])
        PFD_FM_JUMP_WAIT: begin
          if (act[i] && (st_q[1] == x) && !stop_q) begin
            st_d      = pfd_state_t'({~x, 1'b0});         // R1
            cnt_d     = PFD_CNT_RST;
            wait_d[i] = 1'b1;
          end
        end
        PFD_FM_EXEC_WAIT: begin
          if (act[i] && (st_q[1] == x) && !frozen) begin
            st_d  = pfd_state_t'({~x, 1'b0});             // R2
            cnt_d = PFD_CNT_RST;
          end else if (act[i] && !frozen && at_end &&
                       st_q == pfd_state_t'({~x, 1'b1}))
            wait_d[i] = 1'b1;                             // R2
        end
        PFD_FM_EXEC_RUN: begin
          if (act[i] && (st_q[1] == x) && !stop_q) begin
            st_d  = pfd_state_t'({~x, 1'b0});             // R3
            cnt_d = PFD_CNT_RST;
          end else if (act[i] && !frozen && at_end &&
                       st_q == pfd_state_t'({~x, 1'b1}))
            st_d = pfd_state_t'({~x, 1'b0});              // R3
        end
        PFD_FM_DEAD_ONLY, PFD_FM_ALL_WAIT: begin
          if (act[i] && !stop_q && (st_q[0] || (at_end && !frozen))) begin
            st_d  = pfd_state_t'({~st_q[1], 1'b0});       // R5 R6
            cnt_d = PFD_CNT_RST;
            if (fmode[i] == PFD_FM_ALL_WAIT)
              wait_d[i] = 1'b1;                           // R6
          end
        end
        PFD_FM_SW_WAIT: begin
          if (act[i])
            stop_d = 1'b1;                                // R7
        end
        PFD_FM_EDGE_JUMP: begin
          if (rise[i] && !stop_q && st_q == pfd_state_t'({x, 1'b1})) begin
            st_d  = pfd_state_t'({~x, 1'b0});             // R8
            cnt_d = PFD_CNT_RST;
          end
        end
        default: ;
      endcase
      if (!act[i])
        wait_d[i] = 1'b0;
    end
    if (!timer_enable) begin
      st_d   = PFD_DEAD_A;
      cnt_d  = PFD_CNT_RST;
      wait_d = 2'b00;
      stop_d = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // output blanking and waveform outputs
  // ---------------------------------------------------------------
  wire all_off = |{act[0] & (fmode[0] == PFD_FM_ALL_OFF),
                   act[1] & (fmode[1] == PFD_FM_ALL_OFF)};   // R4
  wire [1:0] lvl_off;
  wire [1:0] on_next;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_out
      assign lvl_off[g] = act[g] & (fmode[g] == PFD_FM_LEVEL_BLK); // R10
      assign on_next[g] = (st_d == pfd_state_t'({1'(g), 1'b1}));
      // blanking lasts only to the end of the running on-time
      assign blk_d[g] = on_next[g] & (blk_q[g] | lvl_off[g] |
                        (rise[g] & (fmode[g] == PFD_FM_EDGE_BLK))); // R9 R10
    end
  endgenerate

  wire [1:0] wave_d = {2{timer_enable & ~stop_d & ~all_off}} &
                      on_next & ~blk_d & ~lvl_off;

  // sequence registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q   <= PFD_DEAD_A;
      cnt_q  <= PFD_CNT_RST;
      wait_q <= 2'b00;
      stop_q <= 1'b0;
      blk_q  <= 2'b00;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      wait_q <= wait_d;
      stop_q <= stop_d;
      blk_q  <= blk_d;
    end
  end

  // dither accumulator steps once per completed timer cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= '0;
      ovf_q <= 1'b0;
    end else if (cyc_end) begin
      acc_q <= acc_sum[ACC_W-1:0];                        // R11
      ovf_q <= acc_sum[ACC_W];                            // R12
    end
  end

  // ---------------------------------------------------------------
  // capture units, trigger flags and read port
  // ---------------------------------------------------------------
  logic [15:0] cap_q  [2];
  logic [7:0]  hold_q [2];
  logic [1:0]  flag_q;
  wire  [1:0]  cap_go = (event_action & rise) | sw_capture; // R19 R21
  wire  [1:0]  flag_d = cap_go | (flag_q & ~trigger_flag_clear); // R22
  wire  [15:0] cnt_ext = {{(16 - CNT_W){1'b0}}, cnt_q};

  // capture copies the counter; a set beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cap_q[0] <= 16'h0000;
      cap_q[1] <= 16'h0000;
      flag_q   <= 2'b00;
      trig_irq <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++)
        if (cap_go[i])
          cap_q[i] <= cnt_ext;                            // R18
      flag_q   <= flag_d;
      trig_irq <= |(flag_d & irq_enable_register);        // R23
    end
  end

  // low byte read also freezes the high byte of the same unit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_q[0]       <= PFD_BYTE_RST;
      hold_q[1]       <= PFD_BYTE_RST;
      capture_rd_data <= PFD_BYTE_RST;
    end else if (capture_rd.strobe) begin
      if (capture_rd.high)
        capture_rd_data <= hold_q[capture_rd.unit];       // R20
      else begin
        capture_rd_data          <= cap_q[capture_rd.unit][7:0];
        hold_q[capture_rd.unit]  <= cap_q[capture_rd.unit][15:8]; // R24
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wave_out_first  <= 1'b0;
      wave_out_second <= 1'b0;
      counter_stopped <= 1'b0;
    end else begin
      wave_out_first  <= wave_d[0];
      wave_out_second <= wave_d[1];
      counter_stopped <= stop_d;
    end
  end

  assign trigger_flag_first  = flag_q[0];
  assign trigger_flag_second = flag_q[1];

endmodule

`default_nettype wire

// ===== pfd_top_assertions.sv
// port-level checks of the fault, dither and capture timer
`timescale 1ns/10ps
`default_nettype none
module pfd_top_assertions
  import pfd_pkg::*;
#(
  parameter int CNT_W = 12,
  parameter int ACC_W = 4
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       timer_enable,
  input wire logic [3:0] fault_input_mode_first,
  input wire logic       event_in_first,
  input wire logic       restart_cmd,
  input wire logic [1:0] event_action,
  input wire logic [1:0] sw_capture,
  input wire logic [1:0] irq_enable_register,
  input wire logic [1:0] trigger_flag_clear,
  input wire pfd_rd_t    capture_rd,
  input wire logic       wave_out_first,
  input wire logic       wave_out_second,
  input wire logic       trigger_flag_first,
  input wire logic       trigger_flag_second,
  input wire logic       trig_irq,
  input wire logic [7:0] capture_rd_data,
  input wire logic       counter_stopped
);
  // one clock and one reset for every check
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // capture flags, their causes, the interrupt gate and the read port
  chk_sw_flag: assert property (sw_capture[1] |=> trigger_flag_second)
    else $error("flag not set after software capture");
  chk_flag_hold: assert property (
    trigger_flag_first && !trigger_flag_clear[0] |=> trigger_flag_first)
    else $error("flag dropped without clear");
  chk_irq_gate: assert property (1'b1 |=> trig_irq ==
    |({trigger_flag_second, trigger_flag_first} & $past(irq_enable_register)))
    else $error("interrupt does not follow flags and enables");
  chk_flag_cause: assert property ($rose(trigger_flag_first) |->
    $past(sw_capture[0]) || $past(event_action[0]))
    else $error("flag raised without enabled trigger");
  chk_read_stands: assert property (!capture_rd.strobe |=>
    $stable(capture_rd_data))
    else $error("read data changed without a read");

  // fault modes acting on the waveform outputs and the stop flag
  chk_all_off: assert property ((fault_input_mode_first == PFD_FM_ALL_OFF
    && event_in_first && timer_enable)[*5] |->
    !wave_out_first && !wave_out_second)
    else $error("outputs active during stop-all fault");
  chk_blank_level: assert property ((timer_enable && event_in_first
    && fault_input_mode_first == PFD_FM_LEVEL_BLK)[*5] |-> !wave_out_first)
    else $error("output active during level fault");
  chk_stop_hold: assert property (counter_stopped && !restart_cmd |=>
    counter_stopped)
    else $error("stop released without restart");
endmodule

bind pfd_top pfd_top_assertions #(.CNT_W(CNT_W), .ACC_W(ACC_W))
  u_pfd_top_assertions (.clk(clk), .rst_n(rst_n), .timer_enable(timer_enable),
  .fault_input_mode_first(fault_input_mode_first), .restart_cmd(restart_cmd),
  .event_in_first(event_in_first), .event_action(event_action),
  .sw_capture(sw_capture), .irq_enable_register(irq_enable_register),
  .trigger_flag_clear(trigger_flag_clear), .capture_rd(capture_rd),
  .wave_out_first(wave_out_first), .wave_out_second(wave_out_second),
  .trigger_flag_first(trigger_flag_first), .trig_irq(trig_irq),
  .trigger_flag_second(trigger_flag_second), .counter_stopped(counter_stopped),
  .capture_rd_data(capture_rd_data));
`default_nettype wire

// ===== pfd_fault_source.sv
// stand-in for the event system and power stage fault lines
`timescale 1ns/10ps
`default_nettype none
module pfd_fault_source (
  input  wire logic       clk,
  input  wire logic [1:0] fault_req,
  output var  logic       event_in_first,
  output var  logic       event_in_second
);
  // fault levels start quiet, then follow requests edge by edge
  initial {event_in_second, event_in_first} = 2'b00;
  always @(posedge clk) {event_in_second, event_in_first} <= fault_req;
endmodule
`default_nettype wire

// ===== pfd_fault_dither_capture_test.sv
// self-checking bench of the fault, dither and capture timer
`timescale 1ns/10ps
`default_nettype none
`define check_eq(got, exp) begin total_checks++; \
  if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected %0t got %0h want %0h", $time, got, exp); end end
module pfd_fault_dither_capture_test
  import pfd_pkg::*;
;
  // stimulus and observed signals
  logic       clk, rst_n, timer_enable, restart_cmd, ev_a, ev_b;
  pfd_ramp_t  wave_gen_mode;
  pfd_place_t dither_place_select;
  pfd_lens_t  phase_lens;
  pfd_rd_t    capture_rd;
  logic [3:0] mode_a, mode_b, dither_control;
  logic [1:0] fault_req, event_action, sw_capture, irq_en, flag_clear;
  logic [7:0] capture_rd_data;
  logic       wave_a, wave_b, flag_a, flag_b, trig_irq, stopped;
  int         mismatches, total_checks;

  // free-running clock
  always #25 clk = ~clk;

  // design and fault source
  pfd_top u_pfd_top (.clk(clk), .rst_n(rst_n), .timer_enable(timer_enable),
    .wave_gen_mode(wave_gen_mode), .phase_lens(phase_lens),
    .fault_input_mode_first(mode_a), .fault_input_mode_second(mode_b),
    .event_in_first(ev_a), .event_in_second(ev_b), .restart_cmd(restart_cmd),
    .dither_place_select(dither_place_select), .dither_control(dither_control),
    .event_action(event_action), .sw_capture(sw_capture),
    .irq_enable_register(irq_en), .trigger_flag_clear(flag_clear),
    .capture_rd(capture_rd), .wave_out_first(wave_a), .wave_out_second(wave_b),
    .trigger_flag_first(flag_a), .trigger_flag_second(flag_b),
    .trig_irq(trig_irq), .capture_rd_data(capture_rd_data),
    .counter_stopped(stopped));
  pfd_fault_source u_pfd_fault_source (.clk(clk), .fault_req(fault_req),
    .event_in_first(ev_a), .event_in_second(ev_b));

  // wait edges, then step just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // capture read: low byte first, then the held high byte
  task automatic read_capture(input logic unit, output logic [15:0] v);
    capture_rd = '{strobe: 1'b1, unit: unit, high: 1'b0};
    tick(1);
    v[7:0] = capture_rd_data;
    capture_rd.high = 1'b1;
    tick(1);
    v[15:8] = capture_rd_data;
    capture_rd.strobe = 1'b0;
  endtask

  // count cycles up to the next rise of the second output
  task automatic wait_rise(inout int n);
    logic prev;
    int   k;
    k = 0;
    do begin
      prev = wave_b;
      tick(1);
      n++;
      k++;
    end while (!(prev === 1'b0 && wave_b === 1'b1) && k < 100);
  endtask

  // software and event capture, flags and interrupt gate
  task automatic test_capture();
    logic [15:0] v;
    // long dead time lets the counter reach a known two-byte value
    phase_lens.dead_a = 12'h400;
    timer_enable = 1'b1;
    tick(291);
    sw_capture = 2'b11;
    tick(1);
    sw_capture = 2'b00;
    timer_enable = 1'b0;
    phase_lens.dead_a = 12'h002;
    `check_eq({flag_b, flag_a, trig_irq}, 3'b110)
    read_capture(1'b0, v);
    `check_eq(v, 16'h0123)
    irq_en = 2'b01;
    tick(1);
    `check_eq(trig_irq, 1'b1)
    flag_clear = 2'b11;
    tick(1);
    flag_clear = 2'b00;
    `check_eq({flag_b, flag_a, trig_irq}, 3'b000)
    event_action = 2'b01;
    fault_req = 2'b11;
    tick(8);
    `check_eq({flag_b, flag_a}, 2'b01)
    fault_req = 2'b00;
    event_action = 2'b00;
  endtask

  // each fault mode except 0 and 7 on the first input, outputs observed while held
  task automatic test_fault_modes();
    logic [3:0] md [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9,
      4'ha};
    logic       off_a [9] = '{1, 1, 1, 1, 1, 1, 0, 0, 1};
    logic       off_b [9] = '{1, 1, 0, 1, 1, 1, 0, 0, 0};
    logic [7:0] ca, cb;
    int         k;
    for (int i = 0; i < 9; i++) begin
      mode_a = md[i];
      fault_req = 2'b01;
      tick(14);
      ca = 8'h00;
      cb = 8'h00;
      repeat (20) begin
        tick(1);
        ca += wave_a;
        cb += wave_b;
      end
      `check_eq(ca == 8'h00, off_a[i])
      `check_eq(cb == 8'h00, off_b[i])
      fault_req = 2'b00;
      k = 0;
      // first output back after release shows where the counter resumed
      while (!(wave_a || wave_b) && k < 30) begin
        tick(1);
        k++;
      end
      if (i < 2)
        `check_eq(wave_b, i == 0)
      tick(2);
      mode_a = 4'h0;
      tick(20);
    end
  endtask

  // pulse restart and look at the stop flag afterwards
  task automatic restart_check(input logic exp);
    restart_cmd = 1'b1;
    tick(1);
    restart_cmd = 1'b0;
    tick(3);
    `check_eq(stopped, exp)
  endtask

  // stop until restart, and a restart into a live fault
  task automatic test_sw_stop();
    mode_a = 4'h7;
    fault_req = 2'b01;
    tick(8);
    fault_req = 2'b00;
    tick(8);
    `check_eq({stopped, wave_a, wave_b}, 3'b100)
    restart_check(1'b0);
    fault_req = 2'b01;
    tick(8);
    restart_check(1'b1);
    fault_req = 2'b00;
    tick(6);
    restart_check(1'b0);
    mode_a = 4'h0;
  endtask

  // half-step dither: two periods carry one overflow
  task automatic test_dither();
    pfd_ramp_t  rm [8] = '{PFD_ONE_RAMP, PFD_ONE_RAMP, PFD_ONE_RAMP,
      PFD_TWO_RAMP, PFD_TWO_RAMP, PFD_FOUR_RAMP, PFD_FOUR_RAMP, PFD_DUAL};
    pfd_place_t pl [8] = '{PFD_PL_ON_B, PFD_PL_ON_AB, PFD_PL_DEAD_B,
      PFD_PL_ON_AB, PFD_PL_DEAD_AB, PFD_PL_DEAD_B, PFD_PL_DEAD_AB,
      PFD_PL_ON_AB};
    int         add [8] = '{1, 1, 0, 2, 0, 1, 2, 0};
    int         n;
    dither_control = 4'h8;
    for (int i = 0; i < 8; i++) begin
      wave_gen_mode = rm[i];
      dither_place_select = pl[i];
      tick(30);
      n = 0;
      wait_rise(n);
      n = 0;
      wait_rise(n);
      wait_rise(n);
      `check_eq(n, 20 + add[i])
    end
  endtask

  // counts and verdict, then stop
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // reset, then the scenarios in order
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    timer_enable = 1'b0;
    restart_cmd = 1'b0;
    wave_gen_mode = PFD_ONE_RAMP;
    dither_place_select = PFD_PL_ON_B;
    phase_lens = {12'h002, 12'h003, 12'h002, 12'h003};
    capture_rd = '0;
    {mode_a, mode_b, dither_control} = 12'h000;
    {fault_req, event_action, sw_capture, irq_en, flag_clear} = 10'h000;
    repeat (8) @(posedge clk);
    #2;
    rst_n = 1'b1;
    tick(1);
    test_capture();
    timer_enable = 1'b1;
    tick(20);
    test_fault_modes();
    test_sw_stop();
    test_dither();
    print_verdict();
  end

  // watchdog well beyond the expected run length
  initial begin
    #500000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
